// [ssp_defines.vh]
// Purpose: shared constants of the two-wire slave engine of the sync serial port
// Assumes: included by the engine and its receive buffer
// Notes:   field positions describe the status word that the engine exports
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// mode_select_field encodings
`define SSP_MODE_SLV7       4'h6
`define SSP_MODE_SLV10      4'h7
`define SSP_MODE_FW_MASTER  4'hB
`define SSP_MODE_SLV7_SS    4'hE
`define SSP_MODE_SLV10_SS   4'hF

// port_status_register field positions
`define SSP_ST_BF           0
`define SSP_ST_UA           1
`define SSP_ST_RW           2
`define SSP_ST_START        3
`define SSP_ST_STOP         4
`define SSP_ST_DATA         5

// reset values
`define SSP_ADDR_RST        8'h00
`define SSP_BYTE_RST        8'h00

// bit counts within one byte transfer
`define SSP_BITS_PER_BYTE   4'h8
`define SSP_BIT_CNT_RST     4'h0
`define SSP_BIT_CNT_ONE     4'h1

// receive buffer geometry
`define SSP_BUF_WIDTH       8
`define SSP_BUF_DEPTH       2

`endif

// [ssp_i2c_slave.v]
// Purpose: two-wire slave engine of the sync serial port (7/10-bit addressing)
// Assumes: software controls arrive as single-clock pulses or levels on clk
// Notes:   bus pins are open drain: out is always low, oe pulls the line
//
// Functional notes
// - port idle until module enable set
// - four-bit mode field picks five modes
// - enabled two-wire mode drives pins open drain
// - read-only status: start, stop, data, UA, direction
// - shift register feeds buffer, flag set
// - byte while buffer full sets overflow, dropped
// - own address register, 10-bit high then low
// - pins inputs; slave transmit overrides data line
// - matched address or data gets automatic acknowledge
// - full or overflow: no ack, flag still set
// - read clears buffer full; write clears overflow
// - after start shift eight bits on rise
// - compare bits 7:1 on eighth falling edge
// - match loads buffer, acks, flag on ninth
// - high byte sets UA, holds clock low
// - low byte sets UA again, holds clock
// - 10-bit read header sets no UA
// - start and stop raise the flag in the _SS and firmware master modes
// - wired-AND clock, wait while held low
// - start/stop bits cleared on disable, toggle
// - read match acks, holds clock until release
// - transmit on falling edges, nack ends transfer
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_i2c_slave (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       module_enable_bit,
   input  wire [3:0] mode_select_field,
   input  wire       dir_scl_input,
   input  wire       dir_sda_input,
   input  wire       addr_wr,
   input  wire [7:0] addr_wr_data,
   input  wire       tx_wr,
   input  wire [7:0] tx_wr_data,
   input  wire       clock_release_set,
   input  wire       overflow_clear,
   input  wire       interrupt_clear,
   output wire       rx_valid,
   input  wire       rx_ready,
   output wire [7:0] rx_data,
   input  wire       scl_in,
   output reg        scl_out,
   output reg        scl_oe,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe,
   output reg  [7:0] own_address_register,
   output wire [7:0] port_status_register,
   output reg        receive_overflow_flag,
   output reg        port_interrupt_flag
);
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_RX   = 3'd1;
   localparam [2:0] ST_ACK  = 3'd2;
   localparam [2:0] ST_HOLD = 3'd3;
   localparam [2:0] ST_TX   = 3'd4;
   localparam [2:0] ST_TACK = 3'd5;

   localparam [1:0] TP_HI   = 2'd0;
   localparam [1:0] TP_LOW  = 2'd1;
   localparam [1:0] TP_DONE = 2'd2;

   reg  [2:0] state;
   reg  [3:0] bit_cnt;
   reg  [7:0] shreg;
   reg  [7:0] tx_byte;
   reg        tx_loaded;
   reg  [1:0] ten_phase;
   reg        in_addr;
   reg        ack_pend;
   reg        pull_sda;
   reg        nack;
   reg        buffer_full_flag;
   reg        update_address_flag;
   reg        status_read;
   reg        status_data;
   reg        status_start;
   reg        status_stop;
   reg        scl_m;
   reg        scl_s;
   reg        scl_p;
   reg        sda_m;
   reg        sda_s;
   reg        sda_p;
   reg        push;

   wire       mode_slave;
   wire       mode_i2c;
   wire       mode_ss_irq;
   wire       ten_bit;
   wire       active;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_det;
   wire       stop_det;
   wire       hi_match;
   wire       low_match;
   wire       addr_ok;
   wire       byte_hit;
   wire       room;
   wire       buf_in_ready;
   wire       rx_pop;

   // mode decode; 10-bit modes have bit 0 set
   assign mode_slave  = (mode_select_field == `SSP_MODE_SLV7) ||
                        (mode_select_field == `SSP_MODE_SLV10) ||
                        (mode_select_field == `SSP_MODE_SLV7_SS) ||
                        (mode_select_field == `SSP_MODE_SLV10_SS);
   assign mode_i2c    = mode_slave || (mode_select_field == `SSP_MODE_FW_MASTER);
   assign mode_ss_irq = (mode_select_field == `SSP_MODE_SLV7_SS) ||
                        (mode_select_field == `SSP_MODE_SLV10_SS) ||
                        (mode_select_field == `SSP_MODE_FW_MASTER);
   assign ten_bit     = mode_select_field[0];
   assign active      = module_enable_bit & mode_slave;

   // events come only from the second and third sync stages
   assign scl_rise  = scl_s & ~scl_p;
   assign scl_fall  = ~scl_s & scl_p;
   assign start_det = scl_s & scl_p & ~sda_s & sda_p;
   assign stop_det  = scl_s & scl_p & sda_s & ~sda_p;

   // address comparison: bits 7:1 for 7-bit and the 10-bit header, all 8 for low byte
   assign hi_match  = (shreg[7:1] == own_address_register[7:1]);
   assign low_match = (shreg == own_address_register);
   assign addr_ok   = !ten_bit ? hi_match :
                      (ten_phase == TP_LOW) ? low_match :
                      hi_match & (~shreg[0] | (ten_phase == TP_DONE));
   assign byte_hit  = ~in_addr | addr_ok;
   // a byte may only land when buffer full and overflow are both clear
   assign room      = ~buffer_full_flag & ~receive_overflow_flag & buf_in_ready;
   assign rx_pop    = rx_valid & rx_ready;

   assign port_status_register = {2'b00, status_data, status_stop, status_start,
                                  status_read, update_address_flag,
                                  buffer_full_flag};

   ssp_rx_buf u_rx_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .clear     (~module_enable_bit),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   (shreg),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   // two-flop synchronisers plus one stage of history for edge detection
   always @(posedge clk) begin
      if (!rst_n) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_p <= sda_s;
      end
   end

   // pin drivers: a cleared direction bit pulls low (firmware master),
   // otherwise the slave pulls only while stretching or driving a zero
   always @(posedge clk) begin
      if (!rst_n) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe  <= 1'b0;
         sda_oe  <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe  <= module_enable_bit & mode_i2c &
                    (~dir_scl_input | (active & state == ST_HOLD));
         sda_oe  <= module_enable_bit & mode_i2c &
                    (~dir_sda_input | (active & pull_sda));
      end
   end

   // start/stop status, toggled by bus conditions, cleared while disabled
   always @(posedge clk) begin
      if (!rst_n || !module_enable_bit) begin
         status_start <= 1'b0;
         status_stop  <= 1'b0;
      end else if (start_det) begin
         status_start <= 1'b1;
         status_stop  <= 1'b0;
      end else if (stop_det) begin
         status_start <= 1'b0;
         status_stop  <= 1'b1;
      end
   end

   // transmit holding register; software load stands until the byte is taken
   always @(posedge clk) begin
      if (!rst_n || !module_enable_bit) begin
         tx_byte   <= `SSP_BYTE_RST;
         tx_loaded <= 1'b0;
      end else if (tx_wr) begin
         tx_byte   <= tx_wr_data;
         tx_loaded <= 1'b1;
      end else if (state == ST_HOLD && status_read && clock_release_set) begin
         tx_loaded <= 1'b0;
      end
   end

   // own address register keeps its value over disable
   always @(posedge clk) begin
      if (!rst_n) begin
         own_address_register <= `SSP_ADDR_RST;
      end else if (addr_wr) begin
         own_address_register <= addr_wr_data;
      end
   end

   // main byte engine; hardware sets of sticky flags win over software clears
   always @(posedge clk) begin
      if (!rst_n || !active) begin
         state                 <= ST_IDLE;
         bit_cnt               <= `SSP_BIT_CNT_RST;
         shreg                 <= `SSP_BYTE_RST;
         ten_phase             <= TP_HI;
         in_addr               <= 1'b1;
         ack_pend              <= 1'b0;
         pull_sda              <= 1'b0;
         nack                  <= 1'b0;
         push                  <= 1'b0;
         buffer_full_flag      <= 1'b0;
         update_address_flag   <= 1'b0;
         status_read           <= 1'b0;
         status_data           <= 1'b0;
         receive_overflow_flag <= 1'b0;
         // start/stop flagging continues in firmware master mode
         port_interrupt_flag   <= rst_n & port_interrupt_flag & ~interrupt_clear |
                                  (rst_n & module_enable_bit & mode_ss_irq &
                                   (start_det | stop_det));
      end else begin
         push <= 1'b0;
         // software side clears, overridden below by any hardware set
         if (rx_pop) begin
            buffer_full_flag <= 1'b0;
         end
         if (overflow_clear) begin
            receive_overflow_flag <= 1'b0;
         end
         if (interrupt_clear) begin
            port_interrupt_flag <= 1'b0;
         end
         if ((start_det | stop_det) && mode_ss_irq) begin
            port_interrupt_flag <= 1'b1;
         end
         if (start_det) begin
            // start or repeated start: address byte follows
            state    <= ST_RX;
            bit_cnt  <= `SSP_BIT_CNT_RST;
            in_addr  <= 1'b1;
            pull_sda <= 1'b0;
            if (ten_phase != TP_DONE) begin
               ten_phase <= TP_HI;
            end
         end else if (stop_det) begin
            state     <= ST_IDLE;
            pull_sda  <= 1'b0;
            ten_phase <= TP_HI;
         end else begin
            case (state)
               ST_IDLE: begin
                  pull_sda <= 1'b0;
               end
               ST_RX: begin
                  if (scl_rise) begin
                     shreg   <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + `SSP_BIT_CNT_ONE;
                  end else if (scl_fall && bit_cnt == `SSP_BITS_PER_BYTE) begin
                     if (byte_hit) begin
                        // decide the acknowledge on the eighth falling edge
                        ack_pend <= room;
                        pull_sda <= room;
                        if (buffer_full_flag) begin
                           receive_overflow_flag <= 1'b1;
                        end
                        state <= ST_ACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     // ninth falling edge: end ack, flag, buffer the byte
                     pull_sda            <= 1'b0;
                     port_interrupt_flag <= 1'b1;
                     bit_cnt             <= `SSP_BIT_CNT_RST;
                     status_data         <= ~in_addr;
                     if (ack_pend) begin
                        push             <= 1'b1;
                        buffer_full_flag <= 1'b1;
                     end
                     if (!ack_pend) begin
                        state <= in_addr ? ST_IDLE : ST_RX;
                     end else if (!in_addr) begin
                        state <= ST_RX;
                     end else if (ten_bit && ten_phase == TP_HI) begin
                        update_address_flag <= 1'b1;
                        status_read         <= 1'b0;
                        ten_phase           <= TP_LOW;
                        state               <= ST_HOLD;
                     end else if (ten_bit && ten_phase == TP_LOW) begin
                        update_address_flag <= 1'b1;
                        ten_phase           <= TP_DONE;
                        state               <= ST_HOLD;
                     end else begin
                        // 7-bit match or 10-bit repeated header: no UA here
                        status_read <= shreg[0];
                        in_addr     <= 1'b0;
                        state       <= shreg[0] ? ST_HOLD : ST_RX;
                     end
                  end
               end
               ST_HOLD: begin
                  // clock stretched until software acts
                  if (update_address_flag && addr_wr) begin
                     update_address_flag <= 1'b0;
                     state               <= ST_RX;
                  end else if (status_read && clock_release_set && tx_loaded) begin
                     shreg    <= tx_byte;
                     pull_sda <= ~tx_byte[7];
                     bit_cnt  <= `SSP_BIT_CNT_ONE;
                     state    <= ST_TX;
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt == `SSP_BITS_PER_BYTE) begin
                        pull_sda <= 1'b0;
                        state    <= ST_TACK;
                     end else begin
                        shreg    <= {shreg[6:0], 1'b0};
                        pull_sda <= ~shreg[6];
                        bit_cnt  <= bit_cnt + `SSP_BIT_CNT_ONE;
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     nack <= sda_s;
                  end else if (scl_fall) begin
                     port_interrupt_flag <= 1'b1;
                     status_data         <= 1'b1;
                     state               <= nack ? ST_IDLE : ST_HOLD;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// [ssp_i2c_slave_assertions.sv]
// Purpose: protocol checks on the ports of the two-wire slave engine
// Assumes: single clock domain, synchronous active-low reset
// Notes:   bound to every instance of the engine
`timescale 1ns/1ps
module ssp_i2c_slave_assertions (
   input wire       clk,
   input wire       rst_n,
   input wire       module_enable_bit,
   input wire [3:0] mode_select_field,
   input wire       dir_scl_input,
   input wire       dir_sda_input,
   input wire       addr_wr,
   input wire       clock_release_set,
   input wire       overflow_clear,
   input wire       rx_valid,
   input wire       rx_ready,
   input wire       scl_out,
   input wire       scl_oe,
   input wire       sda_out,
   input wire       sda_oe,
   input wire [7:0] port_status_register,
   input wire       receive_overflow_flag,
   input wire       port_interrupt_flag
);
   wire [7:0] st = port_status_register;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // end of a receive acknowledge, seen as the data line being let go
   sequence ack_end;
      $fell(sda_oe) && !st[2] && dir_sda_input && module_enable_bit;
   endsequence
   chk_ack_flag: assert property (ack_end |-> ##[0:2] port_interrupt_flag)
      else $error("flag not set after receive ack");
   chk_ack_room: assert property ($rose(sda_oe) && !st[2] && dir_sda_input |->
      !receive_overflow_flag && !st[0]) else $error("ack given without room");
   chk_ovf_cause: assert property ($rose(receive_overflow_flag) |-> $past(st[0]))
      else $error("overflow without full buffer");
   chk_ovf_clear: assert property ($fell(receive_overflow_flag) |->
      $past(overflow_clear) || !$past(module_enable_bit)) else $error("overflow lost");
   chk_bf_clear: assert property ($fell(st[0]) |->
      $past(rx_ready) || !$past(module_enable_bit)) else $error("full flag lost");
   chk_ua_mode: assert property ($rose(st[1]) |-> mode_select_field[0])
      else $error("update flag outside 10-bit mode");
   chk_ua_hold: assert property ((st[1] && dir_scl_input)[*3] |-> scl_oe)
      else $error("clock not held while address pending");
   chk_hold_read: assert property (scl_oe && dir_scl_input && module_enable_bit
      && !clock_release_set && !$past(clock_release_set) && !addr_wr && !$past(addr_wr)
      |=> scl_oe) else $error("clock released early");
   chk_off_quiet: assert property (!module_enable_bit[*2] |-> !scl_oe && !sda_oe
      && st[4:0] == 5'h00 && !port_interrupt_flag && !rx_valid) else $error("active while off");
   chk_start_stop: assert property (!(st[3] && st[4]))
      else $error("start and stop both set");
   chk_pins_low: assert property (!scl_out && !sda_out && st[7:6] == 2'h0)
      else $error("open drain level or status pad wrong");
endmodule
bind ssp_i2c_slave ssp_i2c_slave_assertions ssp_i2c_slave_assertions_i (.*);

// [ssp_master_model.sv]
// Purpose: behavioural two-wire bus master facing the slave engine
// Assumes: 160 ns bus clock, both lines pulled up
// Notes:   low phase before bit 1 and the ack bit is stretched so the
//          engine's pin synchroniser delay is covered
`timescale 1ns/1ps
module ssp_master_model (
   input  wire scl,
   input  wire sda,
   output reg  scl_low,
   output reg  sda_low
);
   reg stuck;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      stuck   = 1'b0;
   end
   // release clock, wait while a slave stretches it
   task rise;
      integer n;
      begin
         scl_low = 1'b0;
         n = 0;
         while (!scl && n < 3000) begin
            #20;
            n = n + 1;
         end
         if (!scl) stuck = 1'b1;
      end
   endtask
   task start;
      begin
         sda_low = 1'b0;
         rise;
         #80 sda_low = 1'b1;
         #80 scl_low = 1'b1;
      end
   endtask
   task stop;
      begin
         #160 sda_low = 1'b1;
         rise;
         #80 sda_low = 1'b0;
         #80;
      end
   endtask
   // data changes only while the clock is low; a one is a released line
   task bitx(input v, input integer slow, output got);
      begin
         #(40 + slow) sda_low = !v;
         #40 rise;
         #80 got = sda;
         scl_low = 1'b1;
      end
   endtask
   task xfer(input [7:0] d, input a9, output [7:0] rd, output ak);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bitx(d[i], (i == 7) ? 160 : 0, rd[i]);
         bitx(a9, 160, ak);
      end
   endtask
endmodule

// [ssp_rx_buf.v]
// Purpose: two-entry receive buffer between the shift register and software
// Assumes: single clock, synchronous active-low reset
// Notes:   head entry is always slot 0, so out_data comes straight from a flop
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_rx_buf (
   input  wire                       clk,
   input  wire                       rst_n,
   input  wire                       clear,
   input  wire                       in_valid,
   output wire                       in_ready,
   input  wire [`SSP_BUF_WIDTH-1:0]  in_data,
   output wire                       out_valid,
   input  wire                       out_ready,
   output wire [`SSP_BUF_WIDTH-1:0]  out_data
);
   reg  [`SSP_BUF_WIDTH-1:0] slot [0:`SSP_BUF_DEPTH-1];
   reg  [1:0]                count;
   wire                      push;
   wire                      pop;
   wire [1:0]                wr_idx;
   reg                       valid_q;
   genvar                    g;

   assign in_ready  = (count != 2'd2);
   assign out_valid = valid_q;
   assign out_data  = slot[0];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   // a pop shifts the queue, so the write slot steps back by one
   assign wr_idx    = pop ? count - 2'd1 : count;

   // occupancy count; clear empties the queue when the port is switched off
   always @(posedge clk) begin
      if (!rst_n || clear) begin
         count   <= 2'd0;
         valid_q <= 1'b0;
      end else begin
         count   <= count + {1'b0, push} - {1'b0, pop};
         valid_q <= push | count[1] | (valid_q & ~pop);
      end
   end

   // slot 0 either shifts down on a pop or takes the incoming word; slot 1 only takes the incoming word
   generate
      for (g = 0; g < `SSP_BUF_DEPTH; g = g + 1) begin : gen_slot
         always @(posedge clk) begin
            if (!rst_n) begin
               slot[g] <= `SSP_BYTE_RST;
            end else if (push && wr_idx == g) begin
               slot[g] <= in_data;
            end else if (pop && g < `SSP_BUF_DEPTH - 1) begin
               slot[g] <= slot[(g < `SSP_BUF_DEPTH - 1) ? g + 1 : g];
            end
         end
      end
   endgenerate
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the two-wire slave engine
// Assumes: 50 MHz clock, bus master model on the far side
// Notes:   software controls are one-cycle pulses packed in pv
`timescale 1ns/1ps
module tb_top;
   reg        clk   = 1'b0;
   reg        rst_n = 1'b0;
   reg        en    = 1'b0;
   reg  [3:0] mode  = 4'h6;
   reg  [1:0] dir   = 2'h3;
   reg  [5:0] pv    = 6'h00;
   reg  [7:0] wd    = 8'h00;
   reg  [7:0] rd;
   reg        ak;
   wire       rx_valid, scl_out, scl_oe, sda_out, sda_oe, ovf, irq, m_scl, m_sda;
   wire [7:0] rx_data, own_addr, st;
   wire       scl = !(scl_oe | m_scl);
   wire       sda = !(sda_oe | m_sda);
   integer    miscompares = 0;
   integer    samples_checked = 0;
   always #10 clk = !clk;
   // direction bits are at input, as slave operation needs, except for the fw pull check in t_modes
   ssp_i2c_slave ssp_i2c_slave_i (.clk(clk), .rst_n(rst_n), .module_enable_bit(en),
      .mode_select_field(mode), .dir_scl_input(dir[1]), .dir_sda_input(dir[0]),
      .addr_wr(pv[0]), .addr_wr_data(wd), .tx_wr(pv[1]), .tx_wr_data(wd),
      .clock_release_set(pv[2]), .overflow_clear(pv[3]), .interrupt_clear(pv[4]),
      .rx_valid(rx_valid), .rx_ready(pv[5]), .rx_data(rx_data), .scl_in(scl),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .own_address_register(own_addr), .port_status_register(st),
      .receive_overflow_flag(ovf), .port_interrupt_flag(irq));
   ssp_master_model ssp_master_model_i (.scl(scl), .sda(sda), .scl_low(m_scl),
      .sda_low(m_sda));
   task end_sim;
      begin
         $display("compares %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // a clock held low for good ends the run
   always @(posedge ssp_master_model_i.stuck) begin
      miscompares = miscompares + 1;
      end_sim;
   end
   task ck(input string n, input [7:0] e, input [7:0] s);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value %0s expected %h seen %h", n, e, s);
         end
      end
   endtask
   // one-cycle software pulse
   task pulse(input [5:0] m, input [7:0] d);
      begin
         @(posedge clk);
         pv <= m;
         wd <= d;
         @(posedge clk);
         pv <= 6'h00;
         repeat (2) @(posedge clk);
      end
   endtask
   // bus actions start off the clock edge
   task go(input s);
      begin
         #5;
         if (s) ssp_master_model_i.start;
         else ssp_master_model_i.stop;
         repeat (8) @(posedge clk);
      end
   endtask
   task bus(input [7:0] d, input a9);
      begin
         #5;
         ssp_master_model_i.xfer(d, a9, rd, ak);
         repeat (8) @(posedge clk);
      end
   endtask
   task t_reset;
      begin
         ck("status", 8'h00, st);
         ck("pins", 8'h00, {6'h00, scl_oe, sda_oe});
         ck("address", 8'h00, own_addr);
         ck("flags", 8'h00, {5'h00, ovf, irq, rx_valid});
      end
   endtask
   task t_disabled;
      begin
         pulse(6'h01, 8'hA4);
         go(1);
         bus(8'hA4, 1'b1);
         ck("ack while off", 8'h01, {7'h00, ak});
         ck("rx while off", 8'h00, {7'h00, rx_valid});
         go(0);
      end
   endtask
   task t_modes;
      integer i;
      reg [19:0] m;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            m = 20'h6_7BEF >> (16 - 4 * i);
            @(posedge clk);
            en <= 1'b1;
            mode <= m[3:0];
            pulse(6'h10, 8'h00);
            go(1);
            ck("start bit", 8'h01, {7'h00, st[3]});
            ck("start flag", {7'h00, i > 1}, {7'h00, irq});
            go(0);
            ck("stop bit", 8'h01, {7'h00, st[4]});
         end
         dir  <= 2'h0;
         repeat (2) @(posedge clk);
         ck("fw pull", 8'h03, {6'h00, scl_oe, sda_oe});
         mode <= 4'h0;
         repeat (2) @(posedge clk);
         mode <= 4'h6;
         dir  <= 2'h3;
      end
   endtask
   task t_write;
      begin
         pulse(6'h10, 8'h00);
         go(1);
         bus(8'hA4, 1'b1);
         ck("addr ack", 8'h00, {7'h00, ak});
         ck("addr status", 8'h09, {4'h0, irq, st[5], st[2], st[0]});
         ck("addr byte", 8'hA4, rx_data);
         pulse(6'h30, 8'h00);
         ck("full after read", 8'h00, {7'h00, st[0]});
         bus(8'h3C, 1'b1);
         ck("data ack", 8'h00, {7'h00, ak});
         ck("data status", 8'h0D, {4'h0, irq, st[5], st[2], st[0]});
         ck("data byte", 8'h3C, rx_data);
         pulse(6'h30, 8'h00);
         go(0);
         go(1);
         bus(8'hA6, 1'b1);
         ck("foreign ack", 8'h01, {7'h00, ak});
         ck("foreign rx", 8'h00, {7'h00, rx_valid});
         go(0);
      end
   endtask
   task t_ovf;
      begin
         go(1);
         bus(8'hA4, 1'b1);
         pulse(6'h10, 8'h00);
         bus(8'h11, 1'b1);
         ck("full ack", 8'h01, {7'h00, ak});
         ck("ovf and flag", 8'h03, {6'h00, ovf, irq});
         bus(8'h22, 1'b1);
         ck("ovf ack", 8'h01, {7'h00, ak});
         go(0);
         ck("kept byte", 8'hA4, rx_data);
         pulse(6'h30, 8'h00);
         ck("after read", 8'h01, {6'h00, rx_valid, st[0], ovf});
         pulse(6'h08, 8'h00);
         ck("ovf cleared", 8'h00, {7'h00, ovf});
      end
   endtask
   task t_read;
      begin
         go(1);
         bus(8'hA5, 1'b1);
         ck("read ack", 8'h00, {7'h00, ak});
         ck("read hold", 8'h03, {6'h00, st[2], scl_oe});
         ck("read addr", 8'hA5, rx_data);
         pulse(6'h20, 8'h00);
         pulse(6'h02, 8'h96);
         ck("hold until release", 8'h01, {7'h00, scl_oe});
         pulse(6'h04, 8'h00);
         bus(8'hFF, 1'b1);
         ck("sent byte", 8'h96, rd);
         ck("idle after nack", 8'h00, {6'h00, scl_oe, sda_oe});
         go(0);
      end
   endtask
   task t_ten;
      begin
         @(posedge clk);
         mode <= 4'h7;
         pulse(6'h11, 8'hF2);
         go(1);
         bus(8'hF2, 1'b1);
         ck("header ack", 8'h00, {7'h00, ak});
         ck("header hold", 8'h07, {5'h00, st[1], st[0], scl_oe});
         pulse(6'h21, 8'h5A);
         ck("low loaded", 8'h5A, own_addr);
         ck("ua cleared", 8'h00, {7'h00, st[1]});
         bus(8'h5A, 1'b1);
         ck("low ack", 8'h00, {7'h00, ak});
         ck("low hold", 8'h07, {5'h00, st[1], st[0], scl_oe});
         pulse(6'h21, 8'hF2);
         ck("ua restored", 8'h00, {7'h00, st[1]});
         go(1);
         bus(8'hF3, 1'b1);
         ck("read header", 8'h03, {5'h00, st[1], st[0], st[2]});
         pulse(6'h30, 8'h00);
         @(posedge clk);
         en <= 1'b0;
         repeat (3) @(posedge clk);
         ck("disabled", 8'h00, {3'h0, scl_oe, sda_oe, st[4:3], irq});
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_disabled;
      t_modes;
      t_write;
      t_ovf;
      t_read;
      t_ten;
      end_sim;
   end
endmodule
